/* File: fspr_pkg.sv */
// Constants, register map and types for the flash status controller
// Overview of operation
// RQ1 - Device reports ready in status bit 7; one means ready.
// RQ2 - Device sets status bit 6 while a block erase is suspended.
// RQ3 - Device sets status bit 5 when block or chip erase fails.
// RQ4 - Device sets status bit 4 when any program operation fails.
// RQ5 - Device sets bit 3 and aborts on bad protect pin level.
// RQ6 - Device sets status bit 2 while a program is suspended.
// RQ7 - Device sets bit 1 and aborts on locked block erase/program.
// RQ8 - Status is per partition; ready does not mean sequencer idle.
// RQ9 - Host ignores status bits 6 to 1 while bit 7 reads 0.
// RQ10 - Bits 5 and 4 both set mean an improper command sequence.
// RQ11 - Device samples protect pin level only after erase or program.
// RQ12 - Device checks block lock only after erase or program sequences.
// RQ13 - Lock status is read through identifier-space lock codes.
// RQ14 - Host detects completion by bit 7 or the ready/busy pin.
// RQ15 - Host masks status bits 15 to 8 and bit 0.
// RQ16 - After E8H, extended status bit 7 shows buffer availability.
// RQ17 - Host reissues E8H when buffer unavailable; masks reserved bits.
// RQ18 - Layout 000 one partition; 001, 010, 100 two partitions.
// RQ19 - Layout 011, 110, 101 give three partitions.
// RQ20 - Layout 111 gives four partitions, one per plane.
// RQ21 - Device resets layout to 001 bottom or 100 top variant.
// RQ22 - Host masks layout word bits 15 to 11 and 7 to 0.
package fspr_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int WE_LOW_NS     = 60;
  localparam int OE_LOW_NS     = 80;
  localparam int RECOVER_NS    = 40;
  localparam int SYNC_STAGES   = 2;

  localparam logic [4:0] WE_CYC  =
    5'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] OE_CYC  =
    5'((OE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [4:0] REC_CYC =
    5'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int ADDR_W = 21;
  localparam int DQ_W   = 16;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0C;
  localparam logic [7:0] REG_PSW    = 8'h10;
  localparam logic [7:0] REG_LAYOUT = 8'h14;
  localparam logic [7:0] REG_RDATA  = 8'h18;

  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_WPACC = 4;
  localparam int CTRL_CMD_LO = 8;

  localparam int PSW_READY_BIT = 7;
  localparam int PSW_ERASE_ERR = 5;
  localparam int PSW_PROG_ERR  = 4;
  localparam int ESW_AVAIL_BIT = 7;
  localparam int PLW_LSB       = 8;

  localparam logic [15:0] PSW_VALID_MASK = 16'h00FE;
  localparam logic [15:0] ESW_VALID_MASK = 16'h0080;
  localparam logic [15:0] PLW_VALID_MASK = 16'h0700;

  localparam logic [7:0] CMD_PAGE_BUF = 8'hE8;

  localparam logic [2:0] LAY_ONE  = 3'h0;
  localparam logic [2:0] LAY_FOUR = 3'h7;

  typedef enum logic [2:0] {
    OP_WRITE,
    OP_READ,
    OP_POLL,
    OP_BUFCHK,
    OP_LAYOUT
  } fspr_op_e;

  function automatic logic fspr_mapped(input logic [7:0] a);
    fspr_mapped = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_WDATA)
               || (a == REG_STAT) || (a == REG_PSW) || (a == REG_LAYOUT)
               || (a == REG_RDATA);
  endfunction

endpackage

/* File: fspr_bus_cycle.sv */
// Single asynchronous flash bus cycle engine, read or write
module fspr_bus_cycle
  import fspr_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              start,
  input  wire logic              is_read,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DQ_W-1:0]   wdata,
  output logic                   done,
  output logic [DQ_W-1:0]        rdata,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DQ_W-1:0]       flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [DQ_W-1:0]   flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n
);

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fspr_cyc_e;

  fspr_cyc_e        st_r;
  logic             rd_r;
  logic [4:0]       cnt_r;
  logic [DQ_W-1:0]  dq_meta_r;
  logic [DQ_W-1:0]  dq_sync_r;

  // Data pins cross in from the device
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_meta_r <= '0;
      dq_sync_r <= '0;
    end
    else
    begin
      dq_meta_r <= flash_dq_in;
      dq_sync_r <= dq_meta_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r          <= C_IDLE;
      rd_r          <= 1'b0;
      cnt_r         <= '0;
      done          <= 1'b0;
      rdata         <= '0;
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      case (st_r)
        C_IDLE:
        begin
          if (start)
          begin
            rd_r          <= is_read;
            flash_addr    <= addr;
            flash_dq_out  <= wdata;
            flash_dq_oe_n <= is_read;
            flash_ce_n    <= 1'b0;
            st_r          <= C_SETUP;
          end
        end
        C_SETUP:
        begin
          flash_oe_n <= ~rd_r;
          flash_we_n <= rd_r;
          cnt_r      <= rd_r ? OE_CYC : WE_CYC;
          st_r       <= C_STROBE;
        end
        C_STROBE:
        begin
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h01)
          begin
            if (rd_r)
              rdata <= dq_sync_r;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            cnt_r      <= REC_CYC;
            st_r       <= C_HOLD;
          end
        end
        C_HOLD:
        begin
          // Data held past the strobe edge, then released
          flash_ce_n <= 1'b1;
          cnt_r      <= cnt_r - 5'h01;
          if (cnt_r == 5'h01)
          begin
            flash_dq_oe_n <= 1'b1;
            done          <= 1'b1;
            st_r          <= C_IDLE;
          end
        end
        default:
          st_r <= C_IDLE;
      endcase
    end
  end

endmodule

/* File: fspr_status_decode.sv */
// Masks reserved status bits and decodes the partition layout
module fspr_status_decode
  import fspr_pkg::*;
(
  input  wire logic [DQ_W-1:0] raw_word,
  input  wire logic [2:0]      layout,
  output logic [DQ_W-1:0]      psw_masked,
  output logic                 buf_avail,
  output logic [2:0]           lay_field,
  output logic [1:0]           part_less1,
  output logic                 simult_ok
);

  function automatic logic [1:0] part_count_m1(input logic [2:0] code);
    case (code)
      LAY_ONE:  part_count_m1 = 2'h0;
      LAY_FOUR: part_count_m1 = 2'h3;
      3'h3, 3'h6, 3'h5: part_count_m1 = 2'h2;
      default:  part_count_m1 = 2'h1;
    endcase
  endfunction

  assign psw_masked = raw_word & PSW_VALID_MASK;                  // [RQ15]
  assign buf_avail  = |(raw_word & ESW_VALID_MASK);               // [RQ17]
  assign lay_field  = 3'((raw_word & PLW_VALID_MASK) >> PLW_LSB); // [RQ22]
  assign part_less1 = part_count_m1(layout);        // [RQ18] [RQ19] [RQ20]
  assign simult_ok  = (layout != LAY_ONE);                        // [RQ18]

endmodule

/* File: fspr_host.sv */
// APB-controlled host sequencer for a partitioned NOR flash
module fspr_host
  import fspr_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DQ_W-1:0]        flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [DQ_W-1:0]   flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_protect_accelerate_pin,
  input  wire logic              flash_ready_busy
);

  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_CMD_WAIT, S_PIN, S_READ, S_READ_WAIT, S_EVAL
  } fspr_state_e;

  fspr_state_e        state_r;
  fspr_op_e           op_r;
  logic [7:0]         cmd_r;
  logic [ADDR_W-1:0]  addr_r;
  logic [DQ_W-1:0]    wdata_r;
  logic               done_r;
  logic               buf_avail_r;
  logic [7:0]         retry_r;
  logic [DQ_W-1:0]    psw_r;
  logic [2:0]         layout_r;
  logic               cyc_start_r;
  logic               cyc_rd_r;
  logic [DQ_W-1:0]    cyc_data_r;
  logic               pin_rdy_meta_r;
  logic               pin_rdy_r;

  logic               cyc_done;
  logic [DQ_W-1:0]    rd_word;
  logic [DQ_W-1:0]    psw_masked;
  logic               buf_avail;
  logic [2:0]         lay_field;
  logic [1:0]         part_less1;
  logic               simult_ok;

  logic               apb_acc;
  logic               wr_en;
  logic               go;

  assign apb_acc = psel & penable & ~pready;
  assign wr_en   = psel & penable & pready & pwrite;
  assign go      = wr_en && (paddr == REG_CTRL) && pwdata[CTRL_START]
                   && (state_r == S_IDLE);

  fspr_bus_cycle u_cycle (
    .pclk          (pclk),
    .presetn       (presetn),
    .start         (cyc_start_r),
    .is_read       (cyc_rd_r),
    .addr          (addr_r),
    .wdata         (cyc_data_r),
    .done          (cyc_done),
    .rdata         (rd_word),
    .flash_addr    (flash_addr),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_dq_in   (flash_dq_in),
    .flash_ce_n    (flash_ce_n),
    .flash_oe_n    (flash_oe_n),
    .flash_we_n    (flash_we_n)
  );

  fspr_status_decode u_decode (
    .raw_word   (rd_word),
    .layout     (layout_r),
    .psw_masked (psw_masked),
    .buf_avail  (buf_avail),
    .lay_field  (lay_field),
    .part_less1 (part_less1),
    .simult_ok  (simult_ok)
  );

  // Ready/busy pin crosses in from the device
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_rdy_meta_r <= 1'b0;
      pin_rdy_r      <= 1'b0;
    end
    else
    begin
      pin_rdy_meta_r <= flash_ready_busy;
      pin_rdy_r      <= pin_rdy_meta_r;
    end
  end

  // Software-written settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_r         <= OP_WRITE;
      cmd_r        <= '0;
      addr_r       <= '0;
      wdata_r      <= '0;
      flash_protect_accelerate_pin <= 1'b0;
    end
    else if (wr_en && (state_r == S_IDLE))
    begin
      case (paddr)
        REG_CTRL:
        begin
          op_r         <= fspr_op_e'(pwdata[CTRL_OP_LO +: 3]);
          flash_protect_accelerate_pin <= pwdata[CTRL_WPACC];
          cmd_r        <= pwdata[CTRL_CMD_LO +: 8];
        end
        REG_ADDR:  addr_r  <= pwdata[ADDR_W-1:0];
        REG_WDATA: wdata_r <= pwdata[DQ_W-1:0];
        default:   ;
      endcase
    end
  end

  // Operation sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r     <= S_IDLE;
      cyc_start_r <= 1'b0;
      cyc_rd_r    <= 1'b0;
      cyc_data_r  <= '0;
      done_r      <= 1'b0;
      retry_r     <= '0;
    end
    else
    begin
      cyc_start_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (go)
          begin
            done_r  <= 1'b0;
            retry_r <= '0;
            state_r <= S_CMD;
          end
        end
        S_CMD:
        begin
          cyc_start_r <= 1'b1;
          cyc_rd_r    <= (op_r == OP_READ);
          case (op_r)
            OP_WRITE:  cyc_data_r <= wdata_r;
            OP_BUFCHK: cyc_data_r <= {8'h00, CMD_PAGE_BUF};    // [RQ17]
            default:   cyc_data_r <= {8'h00, cmd_r};
          endcase
          state_r <= S_CMD_WAIT;
        end
        S_CMD_WAIT:
        begin
          if (cyc_done)
          begin
            if (op_r == OP_READ)
              state_r <= S_EVAL;
            else if (op_r == OP_WRITE)
            begin
              done_r  <= 1'b1;
              state_r <= S_IDLE;
            end
            else if (op_r == OP_POLL)
              state_r <= S_PIN;
            else
              state_r <= S_READ;
          end
        end
        S_PIN:
        begin
          if (pin_rdy_r)                                       // [RQ14]
            state_r <= S_READ;
        end
        S_READ:
        begin
          cyc_start_r <= 1'b1;
          cyc_rd_r    <= 1'b1;
          state_r     <= S_READ_WAIT;
        end
        S_READ_WAIT:
        begin
          if (cyc_done)
            state_r <= S_EVAL;
        end
        S_EVAL:
        begin
          if ((op_r == OP_POLL) && !rd_word[PSW_READY_BIT])    // [RQ14]
            state_r <= S_READ;
          else if ((op_r == OP_BUFCHK) && !buf_avail)          // [RQ17]
          begin
            retry_r <= retry_r + 8'h01;
            state_r <= S_CMD;
          end
          else
          begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // Results captured from completed reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      psw_r       <= '0;
      layout_r    <= '0;
      buf_avail_r <= 1'b0;
    end
    else if (state_r == S_EVAL)
    begin
      // Error bits trusted only once ready reads one
      if ((op_r == OP_POLL) && rd_word[PSW_READY_BIT])     // [RQ9] [RQ15]
        psw_r <= psw_masked;
      if (op_r == OP_BUFCHK)
        buf_avail_r <= buf_avail;
      if (op_r == OP_LAYOUT)
        layout_r <= lay_field;                               // [RQ22]
    end
  end

  // APB slave answer, one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= apb_acc;
      pslverr <= apb_acc && !fspr_mapped(paddr);
      prdata  <= '0;
      if (apb_acc && !pwrite)
      begin
        case (paddr)
          REG_CTRL:
            prdata <= {16'h0000, cmd_r, 3'h0, flash_protect_accelerate_pin, op_r, 1'b0};
          REG_ADDR:  prdata <= 32'(addr_r);
          REG_WDATA: prdata <= {16'h0000, wdata_r};
          REG_STAT:
            prdata <= {16'h0000, retry_r, 3'h0, pin_rdy_r,
                       psw_r[PSW_ERASE_ERR] & psw_r[PSW_PROG_ERR],   // [RQ10]
                       buf_avail_r, done_r, state_r != S_IDLE};
          REG_PSW:   prdata <= {16'h0000, psw_r};
          REG_LAYOUT:
            prdata <= {25'h0000000, simult_ok, part_less1, 1'b0, layout_r};
          REG_RDATA: prdata <= {16'h0000, rd_word};
          default:   prdata <= '0;
        endcase
      end
    end
  end

  sequence buf_miss_s;
    (state_r == S_EVAL) && (op_r == OP_BUFCHK) && !buf_avail;
  endsequence

  sequence buf_reissue_s;
    cyc_start_r && !cyc_rd_r && (cyc_data_r[7:0] == CMD_PAGE_BUF);
  endsequence

  chk_buf_reissue: assert property (                            // [RQ17]
    @(posedge pclk) disable iff (!presetn)
    buf_miss_s |-> ##[1:2] buf_reissue_s)
    else $error("buffer check did not reissue page buffer command");

  chk_psw_ready_gate: assert property (                         // [RQ9]
    @(posedge pclk) disable iff (!presetn)
    !$stable(psw_r) |-> psw_r[PSW_READY_BIT])
    else $error("status captured while not ready");

  chk_psw_reserved: assert property (                           // [RQ15]
    @(posedge pclk) disable iff (!presetn)
    (psw_r & ~PSW_VALID_MASK) == 16'h0000)
    else $error("reserved status bits not masked");

  chk_pin_wait: assert property (                               // [RQ14]
    @(posedge pclk) disable iff (!presetn)
    (state_r == S_PIN) && !pin_rdy_r |=> (state_r == S_PIN))
    else $error("poll left pin wait while device busy");

  chk_layout_mask: assert property (                            // [RQ22]
    @(posedge pclk) disable iff (!presetn)
    !$stable(layout_r) |-> (layout_r == $past(rd_word[10:8])))
    else $error("layout field not taken from bits 10 to 8");

endmodule

/* File: fspr_flash_model.sv */
// Behavioural model of the partitioned flash device on the host's far side
module fspr_flash_model
  import fspr_pkg::*;
#(
  parameter logic [2:0] LAYOUT_DEFAULT = 3'h1
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic [DQ_W-1:0]   flash_dq_out,
  input  wire logic              flash_dq_oe_n,
  output logic      [DQ_W-1:0]   flash_dq_in,
  input  wire logic              flash_ce_n,
  input  wire logic              flash_oe_n,
  input  wire logic              flash_we_n,
  output logic                   flash_ready_busy,
  input  wire logic [7:0]        busy_len,
  input  wire logic [7:0]        lag_len,
  input  wire logic [6:1]        psw_flags,
  input  wire logic [7:0]        buf_refusals,
  input  wire logic [2:0]        lay_val,
  input  wire logic              arm
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0]      mode_r;
  logic [6:1]      flags_r;
  logic [7:0]      busy_r;
  logic [7:0]      refuse_r;
  logic [2:0]      layout_r;
  logic            avail_r;
  logic            we_d_r;
  logic [DQ_W-1:0] last_r;
  logic [DQ_W-1:0] word;
  logic            ready_f;
  logic            drive;

  assign ready_f = (busy_r == 8'h00);
  assign drive = !flash_ce_n && !flash_oe_n;
  // Pin may report ready a few cycles before the flag does
  assign flash_ready_busy = (busy_r <= lag_len);
  // Released bus shows the inverse of the last driven word
  assign flash_dq_in = !flash_dq_oe_n ? flash_dq_out
                     : (drive ? word : ~last_r);

  always_comb
  begin
    case (mode_r)
      8'h70:
        word = {8'hFF, ready_f,
                ready_f ? flags_r : ~flags_r,
                1'b1};
      8'hE8:
        word = {8'hFF, avail_r, 7'h7F};
      8'h90:
        // Lock code word: blocks come up locked
        word = flash_addr[1] ? 16'h0001
                             : {5'h1F, layout_r, 8'hFF};
      default:
        word = flash_addr[15:0] ^ 16'hA5A5;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r   <= 8'hFF;
      flags_r  <= 6'h00;
      busy_r   <= 8'h00;
      refuse_r <= 8'h00;
      avail_r  <= 1'b0;
      we_d_r   <= 1'b1;
      last_r   <= 16'h0000;
      layout_r <= LAYOUT_DEFAULT;
    end
    else
    begin
      we_d_r <= flash_we_n;
      if (drive)
        last_r <= word;
      if (busy_r != 8'h00)
        busy_r <= busy_r - 8'h01;
      if (arm)
      begin
        layout_r <= lay_val;
        refuse_r <= buf_refusals;
      end
      // Command taken as the write strobe falls
      if (!flash_we_n && we_d_r && !flash_ce_n)
      begin
        mode_r <= flash_dq_out[7:0];
        if (flash_dq_out[7:0] == 8'h70)
        begin
          busy_r  <= busy_len;
          // Pin level and lock bit looked at only when launched
          flags_r <= psw_flags;
        end
        if (flash_dq_out[7:0] == 8'hE8)
        begin
          avail_r <= (refuse_r == 8'h00);
          if (refuse_r != 8'h00)
            refuse_r <= refuse_r - 8'h01;
        end
      end
    end
  end
endmodule

/* File: tb.sv */
// Self-checking testbench for the flash status host controller
module tb
  import fspr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              pclk, presetn, psel, penable, pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr;
  logic [ADDR_W-1:0] flash_addr;
  logic [DQ_W-1:0]   flash_dq_out, flash_dq_in;
  logic              flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n;
  logic              flash_protect_accelerate_pin, flash_ready_busy, arm;
  logic [7:0]        busy_len, lag_len, buf_refusals;
  logic [6:1]        psw_flags;
  logic [2:0]        lay_val;
  int                miscompares, check_count;

  fspr_host fspr_host_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_addr,
    .flash_dq_out, .flash_dq_oe_n, .flash_dq_in, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .flash_protect_accelerate_pin, .flash_ready_busy);

  fspr_flash_model fspr_flash_model_inst (.pclk, .presetn, .flash_addr,
    .flash_dq_out, .flash_dq_oe_n, .flash_dq_in, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .flash_ready_busy, .busy_len, .lag_len,
    .psw_flags, .buf_refusals, .lay_val, .arm);

  always #20 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    check({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check({31'h0, e}, 32'h0);
  endtask

  // Start one operation and wait for its done flag
  task automatic run_op(input fspr_op_e op, input logic [7:0] cmd,
                        input logic wp, input logic slow);
    logic [31:0] q;
    wr(REG_CTRL, {16'h0, cmd, 3'h0, wp, 3'(op), 1'b1});
    rd(REG_STAT, q);
    if (slow)
      check({31'h0, q[0]}, 32'h1);
    while (q[1] !== 1'b1)
      rd(REG_STAT, q);
    check({31'h0, q[0]}, 32'h0);
  endtask

  task automatic pulse_arm;
    @(posedge pclk);
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
  endtask

  function automatic logic [31:0] lay_exp(input logic [2:0] c);
    lay_exp = {25'h0, c != 3'h0, 2'(c[0]) + 2'(c[1]) + 2'(c[2]), 1'b0, c};
  endfunction

  task automatic test_reset;
    logic [31:0] q;
    logic        e;
    check(32'({flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n}), 32'hF);
    rd(REG_STAT, q);
    check(q, 32'h10);
    apb(1'b0, 8'h1C, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    $display("test reset done");
  endtask

  task automatic test_layout;
    logic [31:0] q;
    run_op(OP_LAYOUT, 8'h90, 1'b0, 1'b0);
    rd(REG_LAYOUT, q);
    check(q, lay_exp(3'h1));
    for (int i = 0; i < 8; i++)
    begin
      lay_val <= 3'(i);
      pulse_arm();
      run_op(OP_LAYOUT, 8'h90, 1'b0, 1'b0);
      rd(REG_LAYOUT, q);
      check(q, lay_exp(3'(i)));
    end
    wr(REG_ADDR, 32'h0000_0002);
    run_op(OP_LAYOUT, 8'h90, 1'b0, 1'b0);
    rd(REG_RDATA, q);
    check(q, 32'h0000_0001);
    $display("test layout done");
  endtask

  task automatic test_rw;
    logic [31:0] q;
    wr(REG_ADDR, 32'h0001_2345);
    wr(REG_WDATA, 32'h0000_00FF);
    run_op(OP_WRITE, 8'h00, 1'b1, 1'b0);
    rd(REG_CTRL, q);
    check(q, {27'h0, 1'b1, 3'(OP_WRITE), 1'b0});
    check({31'h0, flash_protect_accelerate_pin}, 32'h1);
    run_op(OP_READ, 8'h5A, 1'b0, 1'b0);
    rd(REG_RDATA, q);
    check(q, 32'h0000_86E0);
    $display("test read write done");
  endtask

  task automatic test_poll(input logic [6:1] f, input logic [7:0] b,
                           input logic [7:0] l);
    logic [31:0] q;
    logic [31:0] exp;
    psw_flags <= f;
    busy_len <= b;
    lag_len  <= l;
    exp = {24'h0, 1'b1, f, 1'b0};
    run_op(OP_POLL, 8'h70, 1'b0, b != 8'h00);
    rd(REG_PSW, q);
    check(q, exp);
    rd(REG_STAT, q);
    check({31'h0, q[3]}, {31'h0, f[5] & f[4]});
    wr(REG_PSW, 32'hFFFF_FFFF);
    rd(REG_PSW, q);
    check(q, exp);
    $display("test poll done");
  endtask

  task automatic test_buf(input logic [7:0] n);
    logic [31:0] q;
    buf_refusals <= n;
    pulse_arm();
    run_op(OP_BUFCHK, CMD_PAGE_BUF, 1'b0, 1'b0);
    rd(REG_STAT, q);
    check(32'({q[15:8], q[2]}), 32'({n, 1'b1}));
    $display("test buffer done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    final_report();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, arm} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {busy_len, lag_len, buf_refusals} = 24'h0;
    psw_flags = 6'h00;
    lay_val = 3'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_layout();
    test_rw();
    test_poll(6'h15, 8'h00, 8'h00);
    test_poll(6'h18, 8'h1E, 8'h06);
    test_poll(6'h2A, 8'h05, 8'h00);
    test_buf(8'h00);
    test_buf(8'h03);
    final_report();
  end
endmodule
